// ===== core/iadec_top.sv
// Module: slave address recognition after START, with strap-set address
`timescale 1ns/10ps
// Summary of operation
// - One hundred twenty-five fixed addresses come from three five-level pads.
// - Fixed seven-bit address is derived from three five-state strap pads.
// - Pads are sampled and latched at power-up and every reset.
// - After latching, pad sensing switches off and the address is held.
// - Address equals 25*high + 5*mid + low + 1, codes low=0 to high=4.
// - Address byte bit zero is direction: one read, zero write.
// - All-call register resets to E0h, upper seven bits are its address.
// - All-call is enabled from reset and matches both read and write forms.
// - Three sub-call registers reset to EEh, upper seven bits are address.
// - First sub-call enabled at reset, second and third disabled.
// - After an acknowledged write match, the next written byte is the control byte.
module iadec_top #(
    parameter int NUM_SUB = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire iadec_pkg::iadec_strap_t strap_in,
    input wire logic bus_start,
    input wire iadec_pkg::iadec_byte_t bus_byte,
    input wire logic reg_wr,
    input wire logic [1:0] reg_idx,
    input wire logic [7:0] reg_wdata,
    input wire logic [3:0] enable_wr_data,
    input wire logic enable_wr,
    output logic strap_sense_en,
    output logic [6:0] fixed_addr,
    output logic addr_ack,
    output logic dir_read,
    output logic ctrl_byte_valid,
    output logic [7:0] ctrl_byte,
    output logic [3:0] match_src,
    output logic [7:0] reg_rdata
);
    // Elaboration check: enable word and register index are sized for three sub-calls
    if (NUM_SUB != 3)
    begin : g_bad_num_sub
        $error("NUM_SUB must be 3");
    end

    iadec_pkg::iadec_state_t state_q;
    logic [7:0] prog_q [0:3];
    logic [3:0] enable_q;
    logic [6:0] fixed_q;
    logic expect_ctrl_q;
    iadec_pkg::iadec_result_t res;
    logic [6:0] strap_sum;
    logic strap_ok;

    // ==========================================================
    // Strap decode
    // Weighted sum of the three pad codes, offset by one
    always_comb
    begin
        strap_sum = 7'(7'(strap_in.pad_high) * 7'h19 + 7'(strap_in.pad_mid) * 7'h05
            + 7'(strap_in.pad_low) + 7'(iadec_pkg::FIXED_OFFSET));
        strap_ok = (strap_in.pad_high <= iadec_pkg::STRAP_HIGH)
            && (strap_in.pad_mid <= iadec_pkg::STRAP_HIGH)
            && (strap_in.pad_low <= iadec_pkg::STRAP_HIGH);
    end

    // ==========================================================
    // Sequencer
    // Sample pads once after reset, then hunt for address bytes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= iadec_pkg::ST_SAMPLE;
        end
        else
        begin
            case (state_q)
                iadec_pkg::ST_SAMPLE: state_q <= iadec_pkg::ST_IDLE;
                iadec_pkg::ST_IDLE: if (bus_start) state_q <= iadec_pkg::ST_ADDR;
                iadec_pkg::ST_ADDR:
                begin
                    if (bus_start)
                        state_q <= iadec_pkg::ST_ADDR;
                    else if (bus_byte.valid)
                        state_q <= res.match ? iadec_pkg::ST_IDLE : iadec_pkg::ST_IGNORE;
                end
                iadec_pkg::ST_IGNORE: if (bus_start) state_q <= iadec_pkg::ST_ADDR;
                default: state_q <= iadec_pkg::ST_SAMPLE;
            endcase
        end
    end

    // Latch strap address; pads sensed only during reset and the sample state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fixed_q <= 7'h00;
            strap_sense_en <= 1'b1;
        end
        else if (state_q == iadec_pkg::ST_SAMPLE)
        begin
            fixed_q <= strap_ok ? strap_sum : 7'(iadec_pkg::FIXED_OFFSET);
            strap_sense_en <= 1'b0;
        end
    end
    assign fixed_addr = fixed_q;

    // ==========================================================
    // Programmable addresses and enables
    // Volatile registers, back to defaults on every reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prog_q[iadec_pkg::REG_ALL_CALL] <= iadec_pkg::ALL_CALL_RESET;
            prog_q[iadec_pkg::REG_SUB_CALL_1] <= iadec_pkg::SUB_CALL_RESET;
            prog_q[iadec_pkg::REG_SUB_CALL_2] <= iadec_pkg::SUB_CALL_RESET;
            prog_q[iadec_pkg::REG_SUB_CALL_3] <= iadec_pkg::SUB_CALL_RESET;
        end
        else if (reg_wr)
        begin
            prog_q[reg_idx] <= reg_wdata;
        end
    end

    // Bit0 all-call, bits 1..3 sub-call 1..3
    always_ff @(posedge clk)
    begin
        if (rst)
            enable_q <= iadec_pkg::ENABLE_RESET;
        else if (enable_wr)
            enable_q <= enable_wr_data;
    end

    // Read-back of the selected programmable register
    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= prog_q[reg_idx];
    end

    // ==========================================================
    // Address comparison, direction bit ignored in the compare
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SUB + 1; gi++)
        begin : g_cmp
            assign res.src[gi] = enable_q[gi] && (bus_byte.data[iadec_pkg::ADDR_MSB:iadec_pkg::ADDR_LSB]
                == prog_q[gi][iadec_pkg::ADDR_MSB:iadec_pkg::ADDR_LSB]);
        end
    endgenerate
    assign res.match = (bus_byte.data[iadec_pkg::ADDR_MSB:iadec_pkg::ADDR_LSB] == fixed_q)
        || (|res.src);
    assign res.is_read = bus_byte.data[iadec_pkg::DIR_BIT];

    // Ack pulse and match report for the address byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            addr_ack <= 1'b0;
            dir_read <= 1'b0;
            match_src <= 4'h0;
        end
        else
        begin
            addr_ack <= (state_q == iadec_pkg::ST_ADDR) && !bus_start && bus_byte.valid
                && res.match;
            if ((state_q == iadec_pkg::ST_ADDR) && !bus_start && bus_byte.valid && res.match)
            begin
                dir_read <= res.is_read;
                match_src <= res.src;
            end
        end
    end

    // Next written byte after an acked write becomes the control byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            expect_ctrl_q <= 1'b0;
            ctrl_byte_valid <= 1'b0;
            ctrl_byte <= 8'h00;
        end
        else
        begin
            ctrl_byte_valid <= 1'b0;
            if (bus_start)
                expect_ctrl_q <= 1'b0;
            else if ((state_q == iadec_pkg::ST_ADDR) && bus_byte.valid)
                expect_ctrl_q <= res.match && !res.is_read;
            else if (expect_ctrl_q && bus_byte.valid)
            begin
                expect_ctrl_q <= 1'b0;
                ctrl_byte_valid <= 1'b1;
                ctrl_byte <= bus_byte.data;
            end
        end
    end

    // ==========================================================
    // Checks
    a_ack_on_match: assert property (@(posedge clk) disable iff (rst)
        (state_q == iadec_pkg::ST_ADDR && !bus_start && bus_byte.valid && res.match)
        |=> addr_ack) else $error("address match not acknowledged");
    // Recomputed from the registers, so a broken compare path is caught
    a_no_ack_miss: assert property (@(posedge clk) disable iff (rst)
        addr_ack |-> $past((bus_byte.data[7:1] == fixed_q)
        || (enable_q[0] && bus_byte.data[7:1] == prog_q[0][7:1])
        || (enable_q[1] && bus_byte.data[7:1] == prog_q[1][7:1])
        || (enable_q[2] && bus_byte.data[7:1] == prog_q[2][7:1])
        || (enable_q[3] && bus_byte.data[7:1] == prog_q[3][7:1])))
        else $error("ack without match");
    a_sense_off: assert property (@(posedge clk) disable iff (rst)
        (state_q != iadec_pkg::ST_SAMPLE) |-> !strap_sense_en)
        else $error("strap sensing left on");
    a_fixed_hold: assert property (@(posedge clk) disable iff (rst)
        ($past(state_q) != iadec_pkg::ST_SAMPLE && state_q != iadec_pkg::ST_SAMPLE)
        |-> $stable(fixed_q)) else $error("fixed address changed");
    a_sample_first: assert property (@(posedge clk)
        $fell(rst) |-> state_q == iadec_pkg::ST_SAMPLE ##1 state_q == iadec_pkg::ST_IDLE)
        else $error("strap not sampled after reset");
    a_fixed_range: assert property (@(posedge clk) disable iff (rst)
        (state_q != iadec_pkg::ST_SAMPLE) |-> (fixed_q >= 7'h01 && fixed_q <= 7'h7D))
        else $error("fixed address out of range");
    a_dir_bit: assert property (@(posedge clk) disable iff (rst)
        addr_ack |-> dir_read == $past(bus_byte.data[0])) else $error("direction wrong");
    a_reset_enables: assert property (@(posedge clk)
        $past(rst) |-> enable_q == iadec_pkg::ENABLE_RESET
        && prog_q[0] == iadec_pkg::ALL_CALL_RESET && prog_q[3] == iadec_pkg::SUB_CALL_RESET)
        else $error("bad reset values");
    a_ctrl_after_ack: assert property (@(posedge clk) disable iff (rst)
        ctrl_byte_valid |-> !addr_ack && $past(bus_byte.valid)
        && ctrl_byte == $past(bus_byte.data)) else $error("control byte not the next byte");
endmodule

// ===== core/iadec_pkg.sv
// Package: constants and types for the slave address decoder
package iadec_pkg;
    // ==========================================================
    // Strap pad states
    localparam logic [2:0] STRAP_LOW = 3'h0;
    localparam logic [2:0] STRAP_RES_DOWN = 3'h1;
    localparam logic [2:0] STRAP_FLOAT = 3'h2;
    localparam logic [2:0] STRAP_RES_UP = 3'h3;
    localparam logic [2:0] STRAP_HIGH = 3'h4;
    localparam int STRAP_LEVELS = 5;
    localparam int STRAP_PADS = 3;
    localparam int STRAP_COMBOS = 125;
    // ==========================================================
    // Register indices and reset values
    localparam logic [1:0] REG_ALL_CALL = 2'h0;
    localparam logic [1:0] REG_SUB_CALL_1 = 2'h1;
    localparam logic [1:0] REG_SUB_CALL_2 = 2'h2;
    localparam logic [1:0] REG_SUB_CALL_3 = 2'h3;
    localparam logic [7:0] ALL_CALL_RESET = 8'hE0;
    localparam logic [7:0] SUB_CALL_RESET = 8'hEE;
    localparam logic [3:0] ENABLE_RESET = 4'h3;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam int FIXED_OFFSET = 1;
    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [2:0] pad_high;
        logic [2:0] pad_mid;
        logic [2:0] pad_low;
    } iadec_strap_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } iadec_byte_t;
    typedef struct packed {
        logic match;
        logic is_read;
        logic [3:0] src;
    } iadec_result_t;
    typedef enum logic [3:0] {
        ST_SAMPLE = 4'h1,
        ST_IDLE = 4'h2,
        ST_ADDR = 4'h4,
        ST_IGNORE = 4'h8
    } iadec_state_t;
endpackage

// ===== sim/iadec_master_model.sv
// Bus master model: START pulses and received bytes toward the decoder
`timescale 1ns/10ps
module iadec_master_model (
    input wire logic clk,
    output logic bus_start,
    output iadec_pkg::iadec_byte_t bus_byte
);
    // ==========================================
    // Quiet bus at time zero
    initial
    begin
        bus_start = 1'h0;
        bus_byte = '0;
    end
    // One byte; data inverted after release so a stale value never matches
    task automatic put_byte(input logic [7:0] b);
        bus_byte.data = b;
        bus_byte.valid = 1'h1;
        @(negedge clk);
        bus_byte.valid = 1'h0;
        bus_byte.data = ~b;
    endtask
    // START, one quiet cycle, then address with direction in bit zero
    task automatic frame(input logic [7:0] addr);
        @(negedge clk);
        bus_start = 1'h1;
        @(negedge clk);
        bus_start = 1'h0;
        @(negedge clk);
        put_byte(addr);
    endtask
endmodule

// ===== sim/tb_iadec_top.sv
// Self-checking bench for the slave address decoder
`timescale 1ns/10ps
module tb_iadec_top;
    logic clk;
    logic rst;
    iadec_pkg::iadec_strap_t strap_in;
    logic bus_start;
    iadec_pkg::iadec_byte_t bus_byte;
    logic reg_wr;
    logic [1:0] reg_idx;
    logic [7:0] reg_wdata;
    logic [3:0] enable_wr_data;
    logic enable_wr;
    logic strap_sense_en;
    logic [6:0] fixed_addr;
    logic addr_ack;
    logic dir_read;
    logic ctrl_byte_valid;
    logic [7:0] ctrl_byte;
    logic [3:0] match_src;
    logic [7:0] reg_rdata;
    logic [7:0] regs [4];
    logic [7:0] cor [8] = '{8'hE0, 8'hE1, 8'hEE, 8'hEF, 8'h02, 8'h03, 8'h04, 8'h5A};
    logic [3:0] en;
    logic [6:0] fix;
    int n_mismatch;
    int compares;
    int seed;
    // ==========================================
    // Design and bus master
    iadec_top #(.NUM_SUB(3)) i_dut (.clk(clk), .rst(rst), .strap_in(strap_in),
        .bus_start(bus_start), .bus_byte(bus_byte), .reg_wr(reg_wr), .reg_idx(reg_idx),
        .reg_wdata(reg_wdata), .enable_wr_data(enable_wr_data), .enable_wr(enable_wr),
        .strap_sense_en(strap_sense_en), .fixed_addr(fixed_addr), .addr_ack(addr_ack),
        .dir_read(dir_read), .ctrl_byte_valid(ctrl_byte_valid), .ctrl_byte(ctrl_byte),
        .match_src(match_src), .reg_rdata(reg_rdata));
    iadec_master_model i_master (.clk(clk), .bus_start(bus_start), .bus_byte(bus_byte));
    // 100 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Watchdog at 50000 cycles, well past the expected run of under 1400 cycles
    initial
    begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
    // ==========================================
    // Helpers
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    function automatic logic [2:0] rpad();
        return 3'($unsigned($random(seed)) % 5);
    endfunction
    // Which enabled programmable addresses an address byte hits
    function automatic logic [3:0] srcs(input logic [7:0] b);
        logic [3:0] s;
        for (int k = 0; k < 4; k++)
            s[k] = en[k] & (b[7:1] == regs[k][7:1]);
        return s;
    endfunction
    // Fixed address or any enabled programmable address
    function automatic logic hit(input logic [7:0] b);
        return (b[7:1] == fix) | (|srcs(b));
    endfunction
    // Random straps, never landing on a default group address as own address
    function automatic iadec_pkg::iadec_strap_t rstrap();
        iadec_pkg::iadec_strap_t s;
        logic [6:0] a;
        do
        begin
            s = {rpad(), rpad(), rpad()};
            a = 7'(25 * s.pad_high + 5 * s.pad_mid + s.pad_low + 1);
        end
        while (a == iadec_pkg::ALL_CALL_RESET[7:1] || a == iadec_pkg::SUB_CALL_RESET[7:1]);
        return s;
    endfunction
    // Pads change after the latch, so a live sampler would be seen
    task automatic do_reset(input iadec_pkg::iadec_strap_t s);
        strap_in = s;
        rst = 1'h1;
        repeat (12) @(negedge clk);
        check(strap_sense_en, 8'h01);
        rst = 1'h0;
        regs = '{8'hE0, 8'hEE, 8'hEE, 8'hEE};
        en = 4'h3;
        fix = 7'(25 * s.pad_high + 5 * s.pad_mid + s.pad_low + 1);
        repeat (2) @(negedge clk);
        check(strap_sense_en, 8'h00);
        check(fixed_addr, fix);
        strap_in = ~s;
    endtask
    task automatic wr_reg(input logic [1:0] i, input logic [7:0] v);
        @(negedge clk);
        reg_idx = i;
        reg_wdata = v;
        reg_wr = 1'h1;
        regs[i] = v;
        @(negedge clk);
        reg_wr = 1'h0;
    endtask
    task automatic set_en(input logic [3:0] v);
        @(negedge clk);
        enable_wr_data = v;
        enable_wr = 1'h1;
        en = v;
        @(negedge clk);
        enable_wr = 1'h0;
    endtask
    task automatic rd_check(input logic [1:0] i);
        @(negedge clk);
        reg_idx = i;
        @(negedge clk);
        check(reg_rdata, regs[i]);
    endtask
    // Address then a second byte, which counts only after a write ack
    task automatic xfer(input logic [7:0] b);
        logic h;
        h = hit(b);
        i_master.frame(b);
        check(addr_ack, h);
        if (h)
        begin
            check(dir_read, b[0]);
            check(match_src, srcs(b));
        end
        @(negedge clk);
        i_master.put_byte(~b);
        check(ctrl_byte_valid, h & ~b[0]);
        if (h & ~b[0])
            check(ctrl_byte, ~b);
    endtask
    task automatic rand_op();
        logic [31:0] r;
        r = $random(seed);
        case (r[2:0])
            3'h0: wr_reg(r[9:8], r[23:16]);
            3'h1: set_en(r[11:8]);
            3'h2: xfer({fix, r[8]});
            3'h3: xfer({regs[r[9:8]][7:1], r[10]});
            3'h4: rd_check(r[9:8]);
            default: xfer(r[23:16]);
        endcase
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        seed = 48652;
        n_mismatch = 0;
        compares = 0;
        reg_wr = 1'h0;
        reg_idx = 2'h0;
        reg_wdata = 8'h00;
        enable_wr = 1'h0;
        enable_wr_data = 4'h0;
        do_reset(9'h000);
        for (int i = 0; i < 4; i++)
            rd_check(2'(i));
        foreach (cor[k])
            xfer(cor[k]);
        wr_reg(2'h2, 8'h5A);
        xfer(8'h5A);
        set_en(4'hE);
        xfer(8'hE0);
        xfer(8'h5B);
        $display("test defaults done");
        do_reset(9'h124);
        for (int i = 0; i < 4; i++)
            rd_check(2'(i));
        xfer(8'h5A);
        xfer(8'hFA);
        $display("test reset restore done");
        repeat (20)
        begin
            do_reset(rstrap());
            repeat (8) rand_op();
            check(fixed_addr, fix);
        end
        $display("test random done");
        wrap_up();
    end
endmodule
